// [pkg/hmp_pkg.sv]
// Constants for the host mailbox port: local offsets, host offsets, bit positions,
// reset values and the reserved reset command sequence.
// Assumes one clock domain and an active-low board reset.
package hmp_pkg;
    // Local register offsets.
    localparam logic [1:0] LOC_CMD_STS = 2'h0;
    localparam logic [1:0] LOC_DATA = 2'h1;
    localparam logic [1:0] LOC_FLAG_CTL = 2'h2;
    localparam logic [1:0] LOC_VECTOR = 2'h3;
    // Host port offsets.
    localparam logic HOST_CMD_STS = 1'h0;
    localparam logic HOST_DATA = 1'h1;
    // Host status bit positions.
    localparam int ST_DIN_EMPTY = 7;
    localparam int ST_DOUT_AVAIL = 6;
    localparam int ST_USER_HI = 5;
    localparam int ST_USER_LO = 2;
    localparam int ST_CMD_EMPTY = 1;
    localparam int ST_RESET_N = 0;
    // Local flag bit positions.
    localparam int FL_DOUT_EMPTY = 7;
    localparam int FL_DIN_AVAIL = 6;
    localparam int FL_HIRQ_PEND = 3;
    localparam int FL_STS_EMPTY = 1;
    localparam int FL_CMD_AVAIL = 0;
    // Flag positions that always read as one.
    localparam logic [7:0] FL_ONES = 8'h34;
    // Control bit positions.
    localparam int CT_LOC_IE = 2;
    localparam int CT_HOST_IE = 0;
    // Reset values of the handshake state.
    localparam logic RST_DIN_EMPTY = 1'h1;
    localparam logic RST_DOUT_AVAIL = 1'h0;
    localparam logic [3:0] RST_USER = 4'h0;
    localparam logic RST_CMD_EMPTY = 1'h1;
    localparam logic RST_CMD_AVAIL = 1'h0;
    localparam logic RST_STS_EMPTY = 1'h1;
    // Fixed vector returned on a local interrupt acknowledge.
    localparam logic [7:0] LOC_IRQ_VECTOR = 8'hFC;
    // Reserved reset command sequence, first byte in bits 47:40.
    localparam int SEQ_LEN = 6;
    localparam logic [47:0] RESET_SEQ = 48'h7E_55_0F_70_2A_7E;
endpackage

// [verilog/hmp_mailbox.sv]
// Host mailbox port: command, data and status bytes between a bus host and
// the board's local processor, with handshake flags and both interrupt paths.
// Assumes host and local strobes are synchronous to mclk and last one cycle.
`timescale 1ns/100ps

// How it works
// RQ1: Host command byte is latched, read unchanged locally, untouched by reset.
// RQ2: Six-byte command 7E 55 0F 70 2A 7E requests a board reset.
// RQ3: Every host command write sets the local command-available flag.
// RQ4: With local interrupts enabled, every host port access requests a local interrupt.
// RQ5: Status D7 clears on host data write, sets on local read or reset.
// RQ6: Status D6 sets on local data write, clears on host read or reset.
// RQ7: Status D5..D2 hold local software's last write, cleared by reset.
// RQ8: Status D1 follows local writes, clears on host command write, reset sets.
// RQ9: Setting command-empty clears command-available; reset clears it too.
// RQ10: Status D0 shows the board reset line, ignoring local writes.
// RQ11: Inbound data byte survives reset, is overwritten, and re-reads freely.
// RQ12: Outbound data byte survives reset, is overwritten, and re-reads freely.
// RQ13: Flag D7 clears on local data write, sets on host read, reset sets.
// RQ14: Flag D6 sets on host data write, clears on local read, reset clears.
// RQ15: Flag register is read-only; D5, D4 and D2 read as one.
// RQ16: Flag D3 reads one while the host interrupt line is held low.
// RQ17: A vector write with host interrupts enabled signals the host.
// RQ18: Host writes only when the matching empty bit is set, else data is lost.
// RQ19: Host acknowledge returns the vector and releases the request line.
// RQ20: Local interrupt acknowledge returns the fixed vector FCh.
// RQ21: Local interrupt request stays until acknowledged, cleared by reset.
module hmp_mailbox #(
    parameter int DATA_W = 8
) (
    // Clock and board reset.
    input wire logic mclk,
    input wire logic resetn,
    // Host request side.
    input wire logic host_req,
    input wire logic host_we,
    input wire logic host_addr,
    input wire logic [DATA_W-1:0] host_wdata,
    input wire logic host_inta,
    output logic host_ready,
    // Host answer side through the two-entry buffer.
    output logic host_rvalid,
    output logic [DATA_W-1:0] host_rdata,
    input wire logic host_rready,
    output logic host_irq_request_n,
    // Local processor side.
    input wire logic loc_wr,
    input wire logic loc_rd,
    input wire logic [1:0] loc_addr,
    input wire logic [DATA_W-1:0] loc_wdata,
    input wire logic loc_inta,
    output logic [DATA_W-1:0] loc_rdata,
    output logic loc_irq,
    // Pulse asking the reset logic for a board reset.
    output logic board_reset_req
);
    // Handshake and control state.
    logic din_empty_q, din_empty_d;
    logic dout_avail_q, dout_avail_d;
    logic [3:0] user_q, user_d;
    logic cmd_empty_q, cmd_empty_d;
    logic cmd_avail_q, cmd_avail_d;
    logic sts_empty_q, sts_empty_d;
    logic loc_ie_q, loc_ie_d;
    logic host_ie_q, host_ie_d;
    logic hirq_n_q, hirq_n_d;
    logic lirq_q, lirq_d;
    logic [DATA_W-1:0] lrd_q, lrd_d;
    logic [2:0] seq_q, seq_d;
    logic rst_req_q, rst_req_d;
    // Storage that board reset leaves alone.
    logic [DATA_W-1:0] cmd_q, cmd_d;
    logic [DATA_W-1:0] din_q, din_d;
    logic [DATA_W-1:0] dout_q, dout_d;
    logic [DATA_W-1:0] vec_q, vec_d;
    // Answer buffer.
    logic [DATA_W-1:0] buf_q [2];
    logic [DATA_W-1:0] buf_d [2];
    logic [1:0] cnt_q, cnt_d;
    logic rdy_q, rdy_d;
    logic vld_q, vld_d;
    // Decoded events.
    logic take, h_wcmd, h_wdat, h_rsts, h_rdat, h_ack;
    logic push, pop;
    logic [DATA_W-1:0] ans;
    logic [1:0] cnt_mid;
    logic [DATA_W-1:0] status, flags;
    logic [7:0] seq_byte, seq_first;

    // Host accesses are taken only while the answer buffer has room.
    always_comb
    begin
        take = host_req && rdy_q;
        h_wcmd = take && host_we && host_addr == hmp_pkg::HOST_CMD_STS;
        h_wdat = take && host_we && host_addr == hmp_pkg::HOST_DATA;
        h_rsts = take && !host_we && host_addr == hmp_pkg::HOST_CMD_STS;
        h_rdat = take && !host_we && host_addr == hmp_pkg::HOST_DATA;
        h_ack = host_inta && rdy_q && !hirq_n_q && !take;
    end

    // Status byte seen by the host; D0 is one whenever reset is released.
    always_comb
    begin
        status = {din_empty_q, dout_avail_q, user_q, cmd_empty_q, 1'b1}; // [RQ10]
        flags = hmp_pkg::FL_ONES; // [RQ15]
        flags[hmp_pkg::FL_DOUT_EMPTY] = !dout_avail_q;
        flags[hmp_pkg::FL_DIN_AVAIL] = !din_empty_q;
        flags[hmp_pkg::FL_HIRQ_PEND] = !hirq_n_q; // [RQ16]
        flags[hmp_pkg::FL_STS_EMPTY] = sts_empty_q;
        flags[hmp_pkg::FL_CMD_AVAIL] = cmd_avail_q;
    end

    // Handshake, control and interrupt next state; host events come last so
    // that a host event wins over a same-cycle local one unless noted below.
    always_comb
    begin
        din_empty_d = din_empty_q;
        dout_avail_d = dout_avail_q;
        user_d = user_q;
        cmd_empty_d = cmd_empty_q;
        cmd_avail_d = cmd_avail_q;
        sts_empty_d = sts_empty_q;
        loc_ie_d = loc_ie_q;
        host_ie_d = host_ie_q;
        hirq_n_d = hirq_n_q;
        lirq_d = lirq_q;
        lrd_d = lrd_q;
        if (loc_wr)
        begin
            unique case (loc_addr)
                hmp_pkg::LOC_CMD_STS:
                begin
                    user_d = loc_wdata[hmp_pkg::ST_USER_HI:hmp_pkg::ST_USER_LO]; // [RQ7]
                    cmd_empty_d = loc_wdata[hmp_pkg::ST_CMD_EMPTY]; // [RQ8]
                    if (loc_wdata[hmp_pkg::ST_CMD_EMPTY])
                        cmd_avail_d = 1'b0; // [RQ9]
                    sts_empty_d = 1'b0;
                end
                hmp_pkg::LOC_DATA:
                    dout_avail_d = 1'b1; // [RQ6] [RQ13]
                hmp_pkg::LOC_FLAG_CTL:
                begin
                    loc_ie_d = loc_wdata[hmp_pkg::CT_LOC_IE];
                    host_ie_d = loc_wdata[hmp_pkg::CT_HOST_IE];
                end
                hmp_pkg::LOC_VECTOR:
                    if (host_ie_q)
                        hirq_n_d = 1'b0; // [RQ17] [RQ19]
            endcase
        end
        if (loc_rd)
        begin
            unique case (loc_addr)
                hmp_pkg::LOC_CMD_STS: lrd_d = cmd_q; // [RQ1]
                hmp_pkg::LOC_DATA:
                begin
                    lrd_d = din_q; // [RQ11]
                    din_empty_d = 1'b1; // [RQ5] [RQ14]
                end
                hmp_pkg::LOC_FLAG_CTL: lrd_d = flags;
                hmp_pkg::LOC_VECTOR: lrd_d = 8'h00;
            endcase
        end
        if (loc_inta)
        begin
            lrd_d = hmp_pkg::LOC_IRQ_VECTOR; // [RQ20]
            lirq_d = 1'b0; // [RQ21]
        end
        if (h_wcmd)
        begin
            cmd_empty_d = 1'b0; // [RQ8]
            cmd_avail_d = 1'b1; // [RQ3]
        end
        if (h_wdat)
            din_empty_d = 1'b0; // [RQ5] [RQ14]
        // A byte written locally in the cycle of a host read is new, so it stays available.
        if (h_rdat && !(loc_wr && loc_addr == hmp_pkg::LOC_DATA))
            dout_avail_d = 1'b0; // [RQ6] [RQ13]
        if (h_rsts)
            sts_empty_d = 1'b1;
        // A vector loaded in the acknowledge cycle raises a fresh request, which wins.
        if (h_ack && !(loc_wr && loc_addr == hmp_pkg::LOC_VECTOR && host_ie_q))
            hirq_n_d = 1'b1; // [RQ19]
        if (take && loc_ie_q)
            lirq_d = 1'b1; // [RQ4] [RQ21]
    end

    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            din_empty_q <= hmp_pkg::RST_DIN_EMPTY;
            dout_avail_q <= hmp_pkg::RST_DOUT_AVAIL;
            user_q <= hmp_pkg::RST_USER;
            cmd_empty_q <= hmp_pkg::RST_CMD_EMPTY;
            cmd_avail_q <= hmp_pkg::RST_CMD_AVAIL;
            sts_empty_q <= hmp_pkg::RST_STS_EMPTY;
            loc_ie_q <= 1'b0;
            host_ie_q <= 1'b0;
            hirq_n_q <= 1'b1;
            lirq_q <= 1'b0;
            lrd_q <= 8'h00;
        end
        else
        begin
            din_empty_q <= din_empty_d;
            dout_avail_q <= dout_avail_d;
            user_q <= user_d;
            cmd_empty_q <= cmd_empty_d;
            cmd_avail_q <= cmd_avail_d;
            sts_empty_q <= sts_empty_d;
            loc_ie_q <= loc_ie_d;
            host_ie_q <= host_ie_d;
            hirq_n_q <= hirq_n_d;
            lirq_q <= lirq_d;
            lrd_q <= lrd_d;
        end
    end

    // Byte storage; a later write simply replaces an unread byte.
    always_comb
    begin
        cmd_d = h_wcmd ? host_wdata : cmd_q; // [RQ1]
        din_d = h_wdat ? host_wdata : din_q; // [RQ11]
        dout_d = (loc_wr && loc_addr == hmp_pkg::LOC_DATA) ? loc_wdata : dout_q; // [RQ12]
        vec_d = (loc_wr && loc_addr == hmp_pkg::LOC_VECTOR && host_ie_q) ? loc_wdata : vec_q;
    end

    // These bytes keep their content through board reset.
    always_ff @(posedge mclk)
    begin
        cmd_q <= cmd_d;
        din_q <= din_d;
        dout_q <= dout_d;
        vec_q <= vec_d;
    end

    // Reserved sequence detector; a mismatch restarts on the first byte.
    always_comb
    begin
        seq_byte = hmp_pkg::RESET_SEQ[8'(47 - 8 * seq_q) -: 8];
        seq_first = hmp_pkg::RESET_SEQ[47:40];
        seq_d = seq_q;
        rst_req_d = 1'b0;
        if (h_wcmd)
        begin
            if (host_wdata == seq_byte)
            begin
                seq_d = 3'(seq_q + 3'h1);
                if (seq_q == 3'(hmp_pkg::SEQ_LEN - 1))
                begin
                    seq_d = 3'h0;
                    rst_req_d = 1'b1; // [RQ2]
                end
            end
            else
                seq_d = (host_wdata == seq_first) ? 3'h1 : 3'h0; // [RQ2]
        end
    end

    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            seq_q <= 3'h0;
            rst_req_q <= 1'b0;
        end
        else
        begin
            seq_q <= seq_d;
            rst_req_q <= rst_req_d;
        end
    end

    // Two-entry answer buffer; entry 0 is the head shown to the host.
    always_comb
    begin
        ans = h_ack ? vec_q : (h_rsts ? status : dout_q); // [RQ12] [RQ19]
        push = h_rsts || h_rdat || h_ack;
        pop = cnt_q != 2'h0 && host_rready;
        buf_d[0] = buf_q[0];
        buf_d[1] = buf_q[1];
        cnt_mid = cnt_q;
        if (pop)
        begin
            buf_d[0] = buf_q[1];
            cnt_mid = 2'(cnt_q - 2'h1);
        end
        if (push)
            buf_d[cnt_mid[0]] = ans;
        cnt_d = push ? 2'(cnt_mid + 2'h1) : cnt_mid;
        rdy_d = cnt_d != 2'h2;
        vld_d = cnt_d != 2'h0;
    end

    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            buf_q[0] <= 8'h00;
            buf_q[1] <= 8'h00;
            cnt_q <= 2'h0;
            rdy_q <= 1'b1;
            vld_q <= 1'b0;
        end
        else
        begin
            buf_q[0] <= buf_d[0];
            buf_q[1] <= buf_d[1];
            cnt_q <= cnt_d;
            rdy_q <= rdy_d;
            vld_q <= vld_d;
        end
    end

    // Outputs straight from flip-flops.
    assign host_ready = rdy_q;
    assign host_rvalid = vld_q;
    assign host_rdata = buf_q[0];
    assign host_irq_request_n = hirq_n_q; // [RQ16]
    assign loc_rdata = lrd_q;
    assign loc_irq = lirq_q;
    assign board_reset_req = rst_req_q;
endmodule

// [dv/hmp_properties.sv]
// Timing checks on the host mailbox port, bound into hmp_mailbox.
// Assumes one clock, mclk, and the active-low asynchronous resetn.
`timescale 1ns/100ps
module hmp_properties (
    // Clock and reset.
    input wire logic mclk,
    input wire logic resetn,
    // Host side.
    input wire logic host_req,
    input wire logic host_we,
    input wire logic host_addr,
    input wire logic host_inta,
    input wire logic host_ready,
    input wire logic host_rvalid,
    input wire logic [7:0] host_rdata,
    input wire logic host_rready,
    input wire logic host_irq_request_n,
    // Local side.
    input wire logic loc_rd,
    input wire logic [1:0] loc_addr,
    input wire logic loc_inta,
    input wire logic [7:0] loc_rdata,
    input wire logic loc_irq,
    input wire logic board_reset_req
);
    default clocking @(posedge mclk);
    endclocking
    default disable iff (!resetn);
    // A status read taken while the answer buffer is empty.
    sequence s_sts_rd;
        host_req && host_ready && !host_we && !host_addr && !host_rvalid;
    endsequence
    // A host acknowledge that the port honours.
    sequence s_host_ack;
        !host_irq_request_n && host_inta && host_ready && !host_req;
    endsequence
    a_status_reset_bit: assert property (s_sts_rd |=> host_rvalid && host_rdata[0])
        else $error("status answer late or reset bit low");
    a_answer_holds: assert property (host_rvalid && !host_rready |=> host_rvalid && $stable(host_rdata))
        else $error("unaccepted answer changed");
    a_host_ack_release: assert property (s_host_ack |=> host_irq_request_n && host_rvalid)
        else $error("host request not released with vector");
    a_pend_flag: assert property (loc_rd && loc_addr == 2'h2 && !loc_inta |=> loc_rdata[3] == !$past(host_irq_request_n))
        else $error("pending flag wrong");
    a_flag_ones: assert property (loc_rd && loc_addr == 2'h2 && !loc_inta |=> (loc_rdata & 8'h34) == 8'h34)
        else $error("fixed flag bits low");
    a_loc_vector: assert property (loc_inta |=> loc_rdata == 8'hFC)
        else $error("local vector wrong");
    a_loc_irq_hold: assert property (loc_irq && !loc_inta |=> loc_irq)
        else $error("local request dropped early");
    a_loc_irq_drop: assert property (loc_inta && !(host_req && host_ready) |=> !loc_irq)
        else $error("local request kept after ack");
    a_reset_pulse: assert property (board_reset_req |=> !board_reset_req)
        else $error("reset request longer than one cycle");
endmodule
bind hmp_mailbox hmp_properties hmp_properties_i (.mclk(mclk), .resetn(resetn),
    .host_req(host_req), .host_we(host_we), .host_addr(host_addr), .host_inta(host_inta),
    .host_ready(host_ready), .host_rvalid(host_rvalid), .host_rdata(host_rdata),
    .host_rready(host_rready), .host_irq_request_n(host_irq_request_n), .loc_rd(loc_rd),
    .loc_addr(loc_addr), .loc_inta(loc_inta), .loc_rdata(loc_rdata), .loc_irq(loc_irq),
    .board_reset_req(board_reset_req));

// [dv/hmp_host_model.sv]
// Host processor model: requests, acknowledges and answer pops on the host port.
// Assumes the bench calls its tasks at a falling edge of mclk.
`timescale 1ns/100ps
module hmp_host_model (
    // Clock.
    input wire logic mclk,
    // Requests to the port.
    output logic host_req,
    output logic host_we,
    output logic host_addr,
    output logic [7:0] host_wdata,
    output logic host_inta,
    output logic host_rready,
    // Answers from the port.
    input wire logic host_ready,
    input wire logic host_rvalid,
    input wire logic [7:0] host_rdata
);
    // Idle bus at time zero.
    initial
    begin
        {host_req, host_we, host_addr, host_inta, host_rready} = 5'h00;
        host_wdata = 8'hA5;
    end
    // Holds a request until the edge that takes it, then inverts released lines
    // and idles one cycle so that back-to-back calls never touch a line twice at once.
    task automatic put(input logic we, input logic a, input logic [7:0] d);
        logic ok;
        host_req = 1'b1;
        host_we = we;
        host_addr = a;
        host_wdata = d;
        do
        begin
            ok = host_ready;
            @(posedge mclk);
        end
        while (!ok);
        @(negedge mclk);
        host_req = 1'b0;
        host_addr = ~a;
        host_wdata = ~d;
        @(negedge mclk);
    endtask
    // Takes the head answer; a slow host simply calls this late.
    task automatic pop(output logic [7:0] d);
        while (host_rvalid !== 1'b1)
            @(negedge mclk);
        d = host_rdata;
        host_rready = 1'b1;
        @(negedge mclk);
        host_rready = 1'b0;
        @(negedge mclk);
    endtask
    // One-cycle interrupt acknowledge while the port can answer.
    task automatic ack();
        while (host_ready !== 1'b1)
            @(negedge mclk);
        host_inta = 1'b1;
        @(negedge mclk);
        host_inta = 1'b0;
    endtask
endmodule

// [dv/tb_top.sv]
// Self-checking bench for the host mailbox port with a host model on its bus.
// Assumes a 20 MHz mclk and the active-low asynchronous board reset.
`timescale 1ns/100ps
module tb_top;
    logic mclk, resetn, loc_wr, loc_rd, loc_inta, loc_irq, board_reset_req;
    logic host_req, host_we, host_addr, host_inta, host_ready, host_rvalid, host_rready;
    logic host_irq_request_n;
    logic [7:0] host_wdata, host_rdata, loc_wdata, loc_rdata, c, d, o, v, x;
    logic [3:0] u;
    logic [1:0] loc_addr;
    integer err_count = 0, checks = 0, seed = 32'h57411962, cyc = 0, pulses = 0, i;
    hmp_mailbox hmp_mailbox_i (.mclk, .resetn, .host_req, .host_we, .host_addr, .host_wdata,
        .host_inta, .host_ready, .host_rvalid, .host_rdata, .host_rready, .host_irq_request_n,
        .loc_wr, .loc_rd, .loc_addr, .loc_wdata, .loc_inta, .loc_rdata, .loc_irq,
        .board_reset_req);
    hmp_host_model host_m (.mclk, .host_req, .host_we, .host_addr, .host_wdata, .host_inta,
        .host_rready, .host_ready, .host_rvalid, .host_rdata);
    // Clock generation.
    initial
    begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    // Counts reset requests and cuts a hang short.
    always @(posedge mclk)
    begin
        cyc <= cyc + 1;
        if (board_reset_req === 1'b1)
            pulses <= pulses + 1;
        if (cyc == 20000)
        begin
            err_count = err_count + 1;
            report_and_stop();
        end
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks = checks + 1;
        if (seen !== exp)
        begin
            err_count = err_count + 1;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // Expected host status byte.
    function automatic logic [7:0] sts(input logic de, da, input logic [3:0] us, input logic ce);
        return {de, da, us, ce, 1'b1};
    endfunction
    // Local bus accesses, one strobe cycle each, then one idle cycle; hrd is a host read through the host model.
    task automatic lwr(input logic [1:0] a, input logic [7:0] dd);
        loc_wr = 1'b1;
        loc_addr = a;
        loc_wdata = dd;
        @(negedge mclk);
        loc_wr = 1'b0;
        @(negedge mclk);
    endtask
    task automatic lrd(input logic [1:0] a, output logic [7:0] dd);
        loc_rd = 1'b1;
        loc_addr = a;
        @(negedge mclk);
        loc_rd = 1'b0;
        dd = loc_rdata;
        @(negedge mclk);
    endtask
    task automatic hrd(input logic a, output logic [7:0] dd);
        host_m.put(1'b0, a, 8'h00);
        host_m.pop(dd);
    endtask
    // Board reset for six cycles, then the documented reset state.
    task automatic rst();
        resetn = 1'b0;
        repeat (6) @(negedge mclk);
        resetn = 1'b1;
        @(negedge mclk);
        lrd(2'h2, x);
        check(x, 8'hB6);
        hrd(1'b0, x);
        check(x, 8'h83);
        u = 4'h0;
    endtask
    initial
    begin
        {loc_wr, loc_rd, loc_inta, loc_addr, loc_wdata} = 13'h0000;
        rst();
        lwr(2'h2, 8'h05);
        for (i = 0; i < 8; i++)
        begin
            {c, d, o, v} = {$random(seed)};
            host_m.put(1'b1, 1'b0, c);
            lrd(2'h0, x);
            check(x, c);
            lrd(2'h2, x);
            check(x & 8'h01, 8'h01);
            check({7'h0, loc_irq}, 8'h01);
            loc_inta = 1'b1;
            @(negedge mclk);
            loc_inta = 1'b0;
            check(loc_rdata, 8'hFC);
            check({7'h0, loc_irq}, 8'h00);
            host_m.put(1'b1, 1'b1, d);
            hrd(1'b0, x);
            check(x, sts(1'b0, 1'b0, u, 1'b0));
            u = 4'($random(seed));
            lwr(2'h0, {2'b11, u, 2'b11});
            repeat (2) lrd(2'h1, x);
            check(x, d);
            lwr(2'h1, ~o);
            lwr(2'h1, o);
            hrd(1'b0, x);
            check(x, sts(1'b1, 1'b1, u, 1'b1));
            hrd(1'b1, x);
            check(x, o);
            lrd(2'h2, x);
            check(x & 8'hC1, 8'h80);
            lwr(2'h3, v);
            lrd(2'h2, x);
            check({x[3], host_irq_request_n}, 8'h02);
            host_m.ack();
            host_m.pop(x);
            check(x, v);
            check({7'h0, host_irq_request_n}, 8'h01);
        end
        $display("random exchange test done");
        repeat (2) host_m.put(1'b0, 1'b0, 8'h00);
        check({7'h0, host_ready}, 8'h00);
        repeat (2) host_m.pop(x);
        check(x, sts(1'b1, 1'b0, u, 1'b1));
        lwr(2'h2, 8'h04);
        lwr(2'h3, v);
        check({7'h0, host_irq_request_n}, 8'h01);
        lwr(2'h0, 8'h00);
        hrd(1'b0, x);
        check(x, 8'h81);
        $display("buffer and enable test done");
        // Local software frees the command byte after each write, so the host keeps to it.
        for (i = 0; i < 12; i++)
        begin
            host_m.put(1'b1, 1'b0, i == 5 ? 8'h00 : hmp_pkg::RESET_SEQ[47 - 8 * (i % 6) -: 8]);
            lwr(2'h0, 8'h02);
        end
        check(8'(pulses), 8'h01);
        rst();
        lrd(2'h1, x);
        check(x, d);
        lrd(2'h0, x);
        check(x, 8'h7E);
        $display("reset sequence test done");
        report_and_stop();
    end
endmodule
